/* rtl/external_interrupt_latch.sv */
// External interrupt latch: active-low request pin, edge or edge+level sense,
// AXI4-Lite status/control registers, CPU request and vector acknowledge.
// Assumes the CPU applies its own global mask and drives a one-cycle vector acknowledge.
//
// Operation
// - Low request on pin sets the latch
// - Vector fetch acknowledge clears the latch
// - Software acknowledge write clears the latch
// - Any reset clears the latch
// - Default falling edge; optional edge plus level
// - Edge mode: acknowledge clears latch immediately
// - Level mode: clear needs acknowledge and pin high
// - Level mode: pending while pin stays low
// - Reset clears latch and sense select
// - Mask bit blocks request to CPU
// - Edge after acknowledge latches new request
// - Service loads vector from two fixed locations
// - Pending flag ignores the mask bit
// - Pin level offered to branch instructions
// - Pending flag read-only, one when pending
// - Acknowledge bit write-only, reads zero
// - Sense select one means edge plus level
// - In break, acknowledge writes ignored unless enabled
`timescale 1ns/100ps
module external_interrupt_latch (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // Pin and CPU side
  input  wire logic        ext_int_request_pin_in,
  input  wire logic        vector_fetch_ack_in,
  input  wire logic        break_state_in,
  output logic             cpu_irq_out,
  output logic             pin_level_out,
  output logic [15:0]      vector_hi_addr_out,
  output logic [15:0]      vector_lo_addr_out,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic pin_level;
  logic pin_fall;

  pin_sync #(
    .RST_LEVEL (1'b1)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      (ext_int_request_pin_in),
    .level_out   (pin_level),
    .fall_out    (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: capture address and data in either order

  logic [3:0]  aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Control fields live in byte lane 0 only
  logic wr_ctrl;
  logic wr_brk;
  logic wr_hit;

  assign wr_hit  = (aw_addr_q == ext_int_pkg::STATUS_CTRL_OFF) | (aw_addr_q == ext_int_pkg::BREAK_CTRL_OFF);
  assign wr_ctrl = wr_fire & w_strb_q[0] & (aw_addr_q == ext_int_pkg::STATUS_CTRL_OFF);
  assign wr_brk  = wr_fire & w_strb_q[0] & (aw_addr_q == ext_int_pkg::BREAK_CTRL_OFF);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ext_int_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ext_int_pkg::RESP_OKAY : ext_int_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits

  logic mode_q;
  logic mask_q;
  logic break_flag_clear_enable_q;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mode_q <= ext_int_pkg::MODE_RST;
      mask_q <= ext_int_pkg::MASK_RST;
      break_flag_clear_enable_q <= ext_int_pkg::BREAK_FLAG_CLEAR_ENABLE_RST;
    end else begin
      if (wr_ctrl) begin
        mode_q <= w_data_q[ext_int_pkg::MODE_BIT];
        mask_q <= w_data_q[ext_int_pkg::MASK_BIT];
      end
      if (wr_brk) begin
        break_flag_clear_enable_q <= w_data_q[ext_int_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch

  logic latch_q;
  logic ack_pend_q;
  logic sw_ack;
  logic any_ack;
  logic set_req;

  assign sw_ack  = wr_ctrl & w_data_q[ext_int_pkg::ACK_BIT] & (~break_state_in | break_flag_clear_enable_q);
  assign any_ack = sw_ack | vector_fetch_ack_in;
  // falling edge, or low level in level mode
  // new edge after acknowledge sets again
  assign set_req = pin_fall | (mode_q & ~pin_level);

  // Level mode remembers an acknowledge seen while pin still low
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_pend_q <= 1'b0;
    end else if (~mode_q | pin_level | ~latch_q) begin
      ack_pend_q <= 1'b0;
    end else if (any_ack) begin
      ack_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      latch_q <= 1'b0;
    end else if (pin_fall) begin
      // New edge wins over a simultaneous acknowledge
      latch_q <= 1'b1;
    end else if (mode_q) begin
      // clear needs acknowledge and pin high
      if (~pin_level) begin
        latch_q <= 1'b1;
      end else if (any_ack | ack_pend_q) begin
        latch_q <= 1'b0;
      end
    end else if (any_ack) begin
      latch_q <= 1'b0;
    end else if (set_req) begin
      latch_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU side outputs

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cpu_irq_out   <= 1'b0;
      pin_level_out <= 1'b1;
    end else begin
      cpu_irq_out   <= latch_q & ~mask_q & ~any_ack;
      pin_level_out <= pin_level;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      vector_hi_addr_out <= ext_int_pkg::VECTOR_HI_ADDR;
      vector_lo_addr_out <= ext_int_pkg::VECTOR_LO_ADDR;
    end else begin
      vector_hi_addr_out <= ext_int_pkg::VECTOR_HI_ADDR;
      vector_lo_addr_out <= ext_int_pkg::VECTOR_LO_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  function automatic logic [31:0] read_word(input logic [3:0] addr, input logic pend, input logic pin,
                                            input logic mask, input logic mode, input logic break_flag_clear_enable);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr == ext_int_pkg::STATUS_CTRL_OFF) begin
      v[ext_int_pkg::PEND_BIT] = pend;
      v[ext_int_pkg::PIN_BIT]  = pin;
      v[ext_int_pkg::MASK_BIT] = mask;
      v[ext_int_pkg::MODE_BIT] = mode;
    end else if (addr == ext_int_pkg::BREAK_CTRL_OFF) begin
      v[ext_int_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT] = break_flag_clear_enable;
    end
    return v;
  endfunction : read_word

  logic rd_hit;

  assign rd_hit = (s_axi_araddr == ext_int_pkg::STATUS_CTRL_OFF) | (s_axi_araddr == ext_int_pkg::BREAK_CTRL_OFF);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ext_int_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word(s_axi_araddr, latch_q, pin_level, mask_q, mode_q, break_flag_clear_enable_q);
        s_axi_rresp  <= rd_hit ? ext_int_pkg::RESP_OKAY : ext_int_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : external_interrupt_latch

/* rtl/ext_int_pkg.sv */
// Package for the external interrupt latch block: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
package ext_int_pkg;

  localparam int          ADDR_W            = 4;
  localparam int          DATA_W            = 32;
  // Register byte offsets
  localparam logic [3:0]  STATUS_CTRL_OFF   = 4'h0;
  localparam logic [3:0]  BREAK_CTRL_OFF    = 4'h4;
  // Status/control field positions
  localparam int          MODE_BIT          = 0;
  localparam int          MASK_BIT          = 1;
  localparam int          ACK_BIT           = 2;
  localparam int          PEND_BIT          = 3;
  localparam int          PIN_BIT           = 4;
  // Break control field position
  localparam int          BREAK_FLAG_CLEAR_ENABLE_BIT          = 0;
  // Reset values
  localparam logic        MODE_RST          = 1'b0;
  localparam logic        MASK_RST          = 1'b0;
  localparam logic        BREAK_FLAG_CLEAR_ENABLE_RST          = 1'b0;
  // Vector locations used on service
  localparam logic [15:0] VECTOR_HI_ADDR    = 16'hfffa;
  localparam logic [15:0] VECTOR_LO_ADDR    = 16'hfffb;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

endpackage : ext_int_pkg

/* rtl/pin_sync.sv */
// Two-stage synchroniser with falling-edge detect on the synchronised level.
// Assumes the pin input may change at any time relative to the clock.
`timescale 1ns/100ps
module pin_sync #(
  parameter logic RST_LEVEL = 1'b1
) (
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // sync then compare
  // Flops keep sampling through reset, so a pin held low across release is no edge
  always_ff @(posedge core_clk_in) begin
    meta_q <= pin_in;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  assign level_out = sys_rst_in ? RST_LEVEL : sync_q;
  assign fall_out  = prev_q & ~sync_q & ~sys_rst_in;

endmodule : pin_sync

/* dv/ext_int_monitor.sv */
// Port checker for the external interrupt latch.
// Assumes only the top module ports; bound at the foot.
`timescale 1ns/100ps
module ext_int_monitor (
  input wire logic        core_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ext_int_request_pin_in,
  input wire logic        cpu_irq_out,
  input wire logic        pin_level_out,
  input wire logic [15:0] vector_hi_addr_out,
  input wire logic [15:0] vector_lo_addr_out,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=>
    !cpu_irq_out && !s_axi_bvalid && !s_axi_rvalid && pin_level_out) else $error("outputs active after reset");
  a_pin_level_track: assert property ($stable(ext_int_request_pin_in)[*5] |->
    pin_level_out == ext_int_request_pin_in) else $error("pin level not followed");
  a_vector_fixed: assert property (!$past(sys_rst_in) |-> vector_hi_addr_out == ext_int_pkg::VECTOR_HI_ADDR
    && vector_lo_addr_out == ext_int_pkg::VECTOR_LO_ADDR) else $error("vector locations wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ack_reads_zero: assert property (s_axi_rvalid && s_axi_rresp == ext_int_pkg::RESP_OKAY |->
    !s_axi_rdata[ext_int_pkg::ACK_BIT]) else $error("acknowledge bit read as one");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule : ext_int_monitor

bind external_interrupt_latch ext_int_monitor u_mon (.core_clk_in, .sys_rst_in, .ext_int_request_pin_in,
  .cpu_irq_out, .pin_level_out, .vector_hi_addr_out, .vector_lo_addr_out, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp);

/* dv/ext_int_pin_device.sv */
// External device driving the active-low request pin.
// Assumes the bench calls drive after a clock edge.
`timescale 1ns/100ps
module ext_int_pin_device (
  input wire logic clk_in,
  output logic     pin_out
);
  // Pull-up holds the pin high when idle
  initial pin_out = 1'b1;
  task automatic drive(input logic lvl);
    @(posedge clk_in);
    pin_out <= lvl;
  endtask : drive
endmodule : ext_int_pin_device

/* dv/test_external_interrupt_latch.sv */
// Self-checking bench for the external interrupt latch.
// Assumes a pin device model and register access over AXI4-Lite.
`timescale 1ns/100ps
module test_external_interrupt_latch;
  logic core_clk_in, sys_rst_in, ext_int_request_pin_in, vector_fetch_ack_in, break_state_in;
  logic cpu_irq_out, pin_level_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] vector_hi_addr_out, vector_lo_addr_out;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          bad_count, n_tests, m_mode, m_mask, m_latch, m_ackp, m_pin, m_break_flag_clear_enable, i;
  external_interrupt_latch dut (.core_clk_in, .sys_rst_in, .ext_int_request_pin_in, .vector_fetch_ack_in,
    .break_state_in, .cpu_irq_out, .pin_level_out, .vector_hi_addr_out, .vector_lo_addr_out, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  ext_int_pin_device dev (.clk_in(core_clk_in), .pin_out(ext_int_request_pin_in));
  always #4 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw = 1;
    bit w = 1;
    @(posedge core_clk_in);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge core_clk_in);
      if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
    end while (!(s_axi_bvalid && !aw && !w));
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk_in);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge core_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axr
  task automatic setc(input int md, input int mk);
    m_mode = md; m_mask = mk;
    // Read-only pending and pin bits written as ones must change nothing
    axw(ext_int_pkg::STATUS_CTRL_OFF, 32'(24 + m_mask * 2 + m_mode), r);
  endtask : setc
  task automatic pin(input int lvl);
    dev.drive(lvl[0]);
    if (m_pin && !lvl) m_latch = 1;
    m_pin = lvl;
    if (lvl && m_ackp) begin m_latch = 0; m_ackp = 0; end
  endtask : pin
  // Software ack rewrites mask and mode with their current values
  task automatic ack(input int sw);
    if (sw) axw(ext_int_pkg::STATUS_CTRL_OFF, 32'(4 + m_mask * 2 + m_mode), r);
    else begin
      @(posedge core_clk_in); vector_fetch_ack_in <= 1;
      @(posedge core_clk_in); vector_fetch_ack_in <= 0;
    end
    if (sw && break_state_in && !m_break_flag_clear_enable) return;
    if (!m_mode || m_pin) m_latch = 0;
    else m_ackp = 1;
  endtask : ack
  task automatic look();
    repeat (8) @(posedge core_clk_in);
    axr(ext_int_pkg::STATUS_CTRL_OFF, d, r);
    chk("status", 32'(m_pin * 16 + m_latch * 8 + m_mask * 2 + m_mode), d);
    // CPU global mask acts past this output
    chk("irq", 32'(m_latch && !m_mask), 32'(cpu_irq_out));
  endtask : look
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge core_clk_in);
    bad_count++;
    test_done();
  end
  initial begin
    core_clk_in = 0; sys_rst_in = 1; vector_fetch_ack_in = 0; break_state_in = 0; s_axi_awaddr = 4'h0;
    s_axi_awvalid = 0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_araddr = 4'h0; s_axi_arvalid = 0; s_axi_rready = 0; m_pin = 1;
    void'($urandom(32'hd849));
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 0;
    look();
    axr(ext_int_pkg::BREAK_CTRL_OFF, d, r); chk("brk_ctrl", 32'h0, d);
    axr(4'h8, d, r); chk("rresp", 32'(ext_int_pkg::RESP_SLVERR), 32'(r));
    chk("rdata_unmapped", 32'h0, d);
    axw(4'h8, 32'h1, r); chk("bresp", 32'(ext_int_pkg::RESP_SLVERR), 32'(r));
    // Lane 0 disabled: write answered but fields untouched
    s_axi_wstrb <= 4'he;
    axw(ext_int_pkg::STATUS_CTRL_OFF, 32'h3, r); chk("bresp_lane", 32'(ext_int_pkg::RESP_OKAY), 32'(r));
    s_axi_wstrb <= 4'hf;
    look();
    chk("vector", 32'hfffafffb, {vector_hi_addr_out, vector_lo_addr_out});
    for (i = 0; i < 4; i++) begin
      setc(i % 2, i / 2);
      pin(0); look();
      ack(1); look();
      pin(1); look();
      pin(0); look();
      ack(0); look();
      pin(1); look();
      // Pin back high before the acknowledge
      pin(0); pin(1); look();
      ack(1); look();
    end
    setc(0, 0); break_state_in <= 1;
    pin(0); look(); pin(1);
    ack(1); look();
    axw(ext_int_pkg::BREAK_CTRL_OFF, 32'h1, r); m_break_flag_clear_enable = 1;
    axr(ext_int_pkg::BREAK_CTRL_OFF, d, r); chk("brk_ctrl_set", 32'h1, d);
    ack(1); look();
    break_state_in <= 0; look();
    for (i = 0; i < 8; i++) begin
      setc($urandom % 2, $urandom % 2);
      pin(0); repeat (6 + $urandom % 6) @(posedge core_clk_in);
      ack($urandom % 2); look();
      pin(1); look();
    end
    // Pin held low across reset and its release: no request may follow
    setc(1, 0); pin(0); look();
    sys_rst_in <= 1; repeat (3) @(posedge core_clk_in);
    chk("irq_in_reset", 32'h0, 32'(cpu_irq_out));
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 0; m_mode = 0; m_mask = 0; m_latch = 0; m_ackp = 0; m_break_flag_clear_enable = 0;
    look();
    pin(1); look();
    pin(0); look();
    test_done();
  end
endmodule : test_external_interrupt_latch
